// *** core/clk_switch.sv ***
/*
  Glitch-free two-way selector for clock levels built in the system clock domain.
  Assumes both source levels are already synchronous to clock.
*/
module clk_switch (
  input wire logic clock,
  input wire logic reset,
  input wire logic src0,
  input wire logic src1,
  input wire logic sel,
  input wire logic sel_rst,
  output logic out_r
);

  logic sel_r;
  logic sel_nxt;
  logic out_nxt;

  // ==========================================================
  // Hand over only while the output and the new source both sit low
  always_comb begin
    sel_nxt = sel_r;
    if ((sel != sel_r) && !out_r && !(sel ? src1 : src0)) begin
      sel_nxt = sel;
    end
    out_nxt = sel_nxt ? src1 : src0;
  end

  // Registers
  always_ff @(posedge clock) begin
    if (reset) begin
      sel_r <= sel_rst;
      out_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      out_r <= out_nxt;
    end
  end

endmodule : clk_switch

// *** core/clkroute_cfg.svh ***
/*
  Offsets, field positions, reset values and timing counts of the clock routing block.
  Assumes inclusion by bare name from the core/ folder; definitions only.
*/
`ifndef CLKROUTE_CFG_SVH
`define CLKROUTE_CFG_SVH

// ==========================================================
// Register offsets
`define CR_ADDR_PLL_DIV 8'h07
`define CR_ADDR_CLK_SRC 8'h08
`define CR_ADDR_TX_CFG 8'h15
`define CR_ADDR_PLL_INT 8'h20
`define CR_ADDR_K_LO 8'h21
`define CR_ADDR_K_MID 8'h22
`define CR_ADDR_K_HI 8'h23
`define CR_ADDR_PWR 8'h24
`define CR_ADDR_STATUS 8'h25

// ==========================================================
// Field positions
`define CR_AUXDIV_LSB 4
`define CR_MASTER_CLOCK_DIVIDER_SEL_BIT 3
`define CR_FRACTIONAL_MODE_ENABLE_BIT 2
`define CR_MODE_LSB 0
`define CR_AUXSRC_BIT 3
`define CR_PINEN_BIT 4
`define CR_MCLKSRC_BIT 7
`define CR_TX_DATA_SOURCE_SEL_BIT 6
`define CR_PRESCALE_BIT 4
`define CR_PLL_POWER_DOWN_BIT 0
`define CR_RXPD_BIT 1
`define CR_LOCK_BIT 4

// ==========================================================
// Reset values
`define CR_PLL_DIV_RST 8'h14
`define CR_CLK_SRC_RST 8'h18
`define CR_TX_CFG_RST 8'h40
`define CR_N_RST 4'h7
`define CR_K_RST 22'h36fd21
`define CR_PRESCALE_RST 1'b0
`define CR_PWR_RST 8'h03

// ==========================================================
// Timing: clock rate, sample rates in units of 100 Hz, tolerance in percent
`define CR_CLK_HZ 200000000
`define CR_FS_192K 1920
`define CR_FS_176K4 1764
`define CR_FS_96K 960
`define CR_FS_88K2 882
`define CR_FS_48K 480
`define CR_FS_44K1 441
`define CR_FS_32K 320
`define CR_TOL_PCT 1
`define CR_PER_LO(hi_fs) (`CR_CLK_HZ / ((hi_fs) * (100 + `CR_TOL_PCT)))
`define CR_PER_HI(lo_fs) (`CR_CLK_HZ / ((lo_fs) * (100 - `CR_TOL_PCT)))

`endif

// *** core/clkroute_pkg.sv ***
/*
  Types of the clock routing block: rate codes, receiver states and carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package clkroute_pkg;

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    RATE_MODE1 = 2'b00,
    RATE_MODE2 = 2'b01,
    RATE_MODE3 = 2'b10,
    RATE_MODE4 = 2'b11
  } rate_code_e;

  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_TRACK = 1'b1
  } rx_state_e;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic prescale;
    logic frac_en;
    logic [3:0] n;
    logic [21:0] k;
  } pll_cfg_s;

endpackage : clkroute_pkg

// *** core/clock_routing.sv ***
/*
  Clock routing and receive-mode PLL management: aux clock pin, transmitter
  reference, rate classification, PLL ratio tracking and the register port.
  Assumes OSC_EDGE and PLL_EDGE are one-cycle pulses from same-clock logic,
  one per edge of the oscillator and PLL output; RX_FRAME and MCLK_IN are pins.
*/
// How it works
// RULE1 - Aux pin follows divided clock A when source select is 0, oscillator when 1.
// RULE2 - Aux divider field bits 5:4 resets 01, used only with divided clock A.
// RULE3 - Aux pin enable bit 0 tri-states the pin, 1 drives it; resets 1.
// RULE4 - Tx source 0: received data, clock B; 1: audio data, master clock pin.
// RULE5 - Enabled transmitter needs running reference; every listed master clock ratio accepted.
// RULE6 - In receive mode the block trims PLL ratios itself to track the stream.
// RULE7 - Incoming rate classified into four modes, each range widened by about one percent at both ends.
// RULE8 - Software loads the starting PLL ratios before enabling the receiver.
// RULE9 - Software reprograms PLL ratios when mode changes into or out of mode 1.
// RULE10 - Ratios put PLL output at 94.3104 MHz, or 98.304 MHz for 192 kHz.
// RULE11 - While receiving, the block drives the output divide mode itself.
// RULE12 - PLL settings reset to prescale 0, integer 7, fraction 36fd21.
// RULE13 - Prescale 1 halves the oscillator reference toward the PLL; 0 passes it.
// RULE14 - Start-up order: ratios, clear PLL power-down, clear receiver power-down, read code.
// RULE15 - Code cannot split 176.4 from 192 kHz; software supplies mode 1 ratios.
// RULE16 - In receive mode aux codes give 512/256/128/64 fs, master divider 256/128; in mode 1 the code gives aux code 00 256 fs, as for 01.
// RULE17 - Divided clock A factor depends on divide mode and aux code, 2 to 48.
// RULE18 - Software keeps fractional mode enabled whenever the receiver is used.
// RULE19 - Source or divider changes switch outputs without runt pulses.
// RULE20 - Two-bit read-only rate code reports the detected mode, updated on change.
`include "clkroute_cfg.svh"

module clock_routing #(
  parameter int unsigned M1_LO = `CR_PER_LO(`CR_FS_192K),
  parameter int unsigned M1_HI = `CR_PER_HI(`CR_FS_176K4),
  parameter int unsigned M2_LO = `CR_PER_LO(`CR_FS_96K),
  parameter int unsigned M2_HI = `CR_PER_HI(`CR_FS_88K2),
  parameter int unsigned M3_LO = `CR_PER_LO(`CR_FS_48K),
  parameter int unsigned M3_HI = `CR_PER_HI(`CR_FS_44K1),
  parameter int unsigned M4_LO = `CR_PER_LO(`CR_FS_32K),
  parameter int unsigned M4_HI = `CR_PER_HI(`CR_FS_32K)
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire clkroute_pkg::reg_req_s REG_REQ,
  output logic [7:0] RDATA,
  input wire logic OSC_EDGE,
  input wire logic PLL_EDGE,
  input wire logic RX_FRAME,
  input wire logic MCLK_IN,
  output clkroute_pkg::pll_cfg_s PLL_CFG,
  output logic [1:0] PLL_DIV_MODE,
  output logic PLL_REF_EDGE,
  output logic PLL_PD,
  output logic RX_PD,
  output logic AUX_CLK_O,
  output logic AUX_CLK_OE,
  output logic TX_DATA_SEL,
  output logic TX_REF_CLK,
  output logic MCLK_SRC_SEL
);

  // ==========================================================
  // Divide factor in PLL output edges per half period
  function automatic logic [5:0] div_factor(input logic [1:0] mode, input logic [1:0] dsel);
    logic [5:0] base;
    logic [5:0] f;
    base = 6'h01;
    unique case (mode)
      2'b00: base = 6'h01;
      2'b01: base = 6'h02;
      2'b10: base = 6'h04;
      2'b11: base = 6'h06;
    endcase
    f = base << dsel;
    div_factor = (f < 6'h02) ? 6'h02 : f;
  endfunction : div_factor

  // Frame period to rate mode; bit 2 flags a valid class
  function automatic logic [2:0] classify(input logic [13:0] per);
    classify = 3'h0;
    if (per >= M1_LO[13:0] && per <= M1_HI[13:0]) begin
      classify = {1'b1, clkroute_pkg::RATE_MODE1}; // RULE15
    end else if (per >= M2_LO[13:0] && per <= M2_HI[13:0]) begin
      classify = {1'b1, clkroute_pkg::RATE_MODE2};
    end else if (per >= M3_LO[13:0] && per <= M3_HI[13:0]) begin
      classify = {1'b1, clkroute_pkg::RATE_MODE3};
    end else if (per >= M4_LO[13:0] && per <= M4_HI[13:0]) begin
      classify = {1'b1, clkroute_pkg::RATE_MODE4};
    end
  endfunction : classify

  // ==========================================================
  // Register file
  logic [7:0] pll_div_r, pll_div_nxt;
  logic [7:0] clk_src_r, clk_src_nxt;
  logic [7:0] tx_cfg_r, tx_cfg_nxt;
  logic [3:0] n_r, n_nxt;
  logic prescale_r, prescale_nxt;
  logic [21:0] k_r, k_nxt;
  logic [7:0] pwr_r, pwr_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [1:0] rate_code_r;
  logic locked_r;
  logic [1:0] eff_mode;

  // Decode writes and reads
  always_comb begin
    pll_div_nxt = pll_div_r;
    clk_src_nxt = clk_src_r;
    tx_cfg_nxt = tx_cfg_r;
    n_nxt = n_r;
    prescale_nxt = prescale_r;
    k_nxt = k_r;
    pwr_nxt = pwr_r;
    rdata_nxt = 8'h00;
    if (REG_REQ.wr) begin
      unique case (REG_REQ.addr)
        `CR_ADDR_PLL_DIV: pll_div_nxt = REG_REQ.wdata;
        `CR_ADDR_CLK_SRC: clk_src_nxt = REG_REQ.wdata;
        `CR_ADDR_TX_CFG: tx_cfg_nxt = REG_REQ.wdata;
        `CR_ADDR_PLL_INT: begin
          n_nxt = REG_REQ.wdata[3:0];
          prescale_nxt = REG_REQ.wdata[`CR_PRESCALE_BIT];
        end
        `CR_ADDR_K_LO: k_nxt[7:0] = REG_REQ.wdata;
        `CR_ADDR_K_MID: k_nxt[15:8] = REG_REQ.wdata;
        `CR_ADDR_K_HI: k_nxt[21:16] = REG_REQ.wdata[5:0];
        `CR_ADDR_PWR: pwr_nxt = {6'h00, REG_REQ.wdata[1:0]};
        default: ;
      endcase
    end
    if (REG_REQ.rd) begin
      unique case (REG_REQ.addr)
        `CR_ADDR_PLL_DIV: rdata_nxt = pll_div_r;
        `CR_ADDR_CLK_SRC: rdata_nxt = clk_src_r;
        `CR_ADDR_TX_CFG: rdata_nxt = tx_cfg_r;
        `CR_ADDR_PLL_INT: rdata_nxt = {3'h0, prescale_r, n_r};
        `CR_ADDR_K_LO: rdata_nxt = k_r[7:0];
        `CR_ADDR_K_MID: rdata_nxt = k_r[15:8];
        `CR_ADDR_K_HI: rdata_nxt = {2'h0, k_r[21:16]};
        `CR_ADDR_PWR: rdata_nxt = pwr_r;
        `CR_ADDR_STATUS: rdata_nxt = {3'h0, locked_r, eff_mode, rate_code_r}; // RULE20
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Register the file; reset values set the 12 MHz receive defaults
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pll_div_r <= `CR_PLL_DIV_RST; // RULE2
      clk_src_r <= `CR_CLK_SRC_RST; // RULE1
      tx_cfg_r <= `CR_TX_CFG_RST; // RULE4
      n_r <= `CR_N_RST; // RULE12
      prescale_r <= `CR_PRESCALE_RST;
      k_r <= `CR_K_RST;
      pwr_r <= `CR_PWR_RST;
      rdata_r <= 8'h00;
    end else begin
      pll_div_r <= pll_div_nxt;
      clk_src_r <= clk_src_nxt;
      tx_cfg_r <= tx_cfg_nxt;
      n_r <= n_nxt;
      prescale_r <= prescale_nxt;
      k_r <= k_nxt;
      pwr_r <= pwr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;

  // ==========================================================
  // Pin synchronisers
  logic frame_s1_r, frame_s2_r, frame_d_r;
  logic mclk_s1_r, mclk_s2_r;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      frame_s1_r <= 1'b0;
      frame_s2_r <= 1'b0;
      frame_d_r <= 1'b0;
      mclk_s1_r <= 1'b0;
      mclk_s2_r <= 1'b0;
    end else begin
      frame_s1_r <= RX_FRAME;
      frame_s2_r <= frame_s1_r;
      frame_d_r <= frame_s2_r;
      mclk_s1_r <= MCLK_IN;
      mclk_s2_r <= mclk_s1_r;
    end
  end

  logic frame_edge;
  assign frame_edge = frame_s2_r && !frame_d_r;

  // ==========================================================
  // Receiver: rate classification and ratio tracking
  clkroute_pkg::rx_state_e rx_state_r, rx_state_nxt;
  logic [13:0] per_cnt_r, per_cnt_nxt;
  logic [13:0] last_per_r, last_per_nxt;
  logic [1:0] rate_code_nxt;
  logic locked_nxt;
  logic signed [7:0] trim_r, trim_nxt;
  logic [2:0] cls;
  logic rx_active;

  assign rx_active = !pwr_r[`CR_RXPD_BIT] && !pwr_r[`CR_PLL_POWER_DOWN_BIT];
  assign cls = classify(per_cnt_r);

  // Measure frame period, classify, and nudge the fraction
  always_comb begin
    rx_state_nxt = rx_state_r;
    per_cnt_nxt = per_cnt_r;
    last_per_nxt = last_per_r;
    rate_code_nxt = rate_code_r;
    locked_nxt = locked_r;
    trim_nxt = trim_r;
    unique case (rx_state_r)
      clkroute_pkg::RX_IDLE: begin
        per_cnt_nxt = 14'h0000;
        trim_nxt = 8'sh00;
        locked_nxt = 1'b0;
        if (rx_active) begin
          rx_state_nxt = clkroute_pkg::RX_TRACK;
        end
      end
      clkroute_pkg::RX_TRACK: begin
        if (per_cnt_r != 14'h3fff) begin
          per_cnt_nxt = per_cnt_r + 14'h0001;
        end else begin
          locked_nxt = 1'b0; // Stream lost
        end
        if (frame_edge) begin
          per_cnt_nxt = 14'h0001;
          last_per_nxt = per_cnt_r;
          locked_nxt = cls[2];
          if (cls[2]) begin
            rate_code_nxt = cls[1:0]; // RULE7
          end
          if (per_cnt_r > last_per_r && trim_r != 8'sh7f) begin
            trim_nxt = trim_r + 8'sh01; // RULE6
          end else if (per_cnt_r < last_per_r && trim_r != -8'sh80) begin
            trim_nxt = trim_r - 8'sh01; // RULE6
          end
        end
        if (!rx_active) begin
          rx_state_nxt = clkroute_pkg::RX_IDLE;
        end
      end
    endcase
  end

  // Register receiver state
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rx_state_r <= clkroute_pkg::RX_IDLE;
      per_cnt_r <= 14'h0000;
      last_per_r <= 14'h0000;
      rate_code_r <= clkroute_pkg::RATE_MODE3;
      locked_r <= 1'b0;
      trim_r <= 8'sh00;
    end else begin
      rx_state_r <= rx_state_nxt;
      per_cnt_r <= per_cnt_nxt;
      last_per_r <= last_per_nxt;
      rate_code_r <= rate_code_nxt;
      locked_r <= locked_nxt;
      trim_r <= trim_nxt;
    end
  end

  // Divide mode: receiver owns it while active
  assign eff_mode = (rx_state_r == clkroute_pkg::RX_TRACK) ? rate_code_r : pll_div_r[1:0]; // RULE11

  // ==========================================================
  // PLL settings out, fraction trimmed while tracking
  clkroute_pkg::pll_cfg_s pll_cfg_r, pll_cfg_nxt;

  always_comb begin
    pll_cfg_nxt.prescale = prescale_r;
    pll_cfg_nxt.frac_en = pll_div_r[`CR_FRACTIONAL_MODE_ENABLE_BIT];
    pll_cfg_nxt.n = n_r;
    pll_cfg_nxt.k = k_r + {{14{trim_r[7]}}, trim_r}; // RULE6
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pll_cfg_r <= {`CR_PRESCALE_RST, 1'b1, `CR_N_RST, `CR_K_RST};
    end else begin
      pll_cfg_r <= pll_cfg_nxt;
    end
  end

  assign PLL_CFG = pll_cfg_r;
  assign PLL_DIV_MODE = eff_mode;
  assign PLL_PD = pwr_r[`CR_PLL_POWER_DOWN_BIT];
  assign RX_PD = pwr_r[`CR_RXPD_BIT];

  // ==========================================================
  // Oscillator level and prescaled PLL reference
  logic osc_lvl_r, osc_lvl_nxt;
  logic pre_r, pre_nxt;
  logic ref_seen_r, ref_seen_nxt;

  // Ref seen: last oscillator edge passed a reference pulse under prescale
  always_comb begin
    osc_lvl_nxt = OSC_EDGE ? !osc_lvl_r : osc_lvl_r;
    pre_nxt = OSC_EDGE ? !pre_r : pre_r;
    ref_seen_nxt = prescale_r && (OSC_EDGE ? PLL_REF_EDGE : ref_seen_r);
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      osc_lvl_r <= 1'b0;
      pre_r <= 1'b0;
      ref_seen_r <= 1'b0;
    end else begin
      osc_lvl_r <= osc_lvl_nxt;
      pre_r <= pre_nxt;
      ref_seen_r <= ref_seen_nxt;
    end
  end

  assign PLL_REF_EDGE = OSC_EDGE && (!prescale_r || pre_r); // RULE13

  // ==========================================================
  // Divided clocks A and B; factor reloads only at a toggle
  logic clka_r, clka_nxt, clkb_r, clkb_nxt;
  logic [5:0] cnta_r, cnta_nxt, cntb_r, cntb_nxt;
  logic [5:0] faca_r, faca_nxt, facb_r, facb_nxt;

  always_comb begin
    clka_nxt = clka_r;
    cnta_nxt = cnta_r;
    faca_nxt = faca_r;
    clkb_nxt = clkb_r;
    cntb_nxt = cntb_r;
    facb_nxt = facb_r;
    if (PLL_EDGE) begin
      cnta_nxt = cnta_r + 6'h01;
      cntb_nxt = cntb_r + 6'h01;
      if (cnta_r + 6'h01 >= faca_r) begin
        clka_nxt = !clka_r; // RULE19
        cnta_nxt = 6'h00;
        faca_nxt = div_factor(eff_mode, pll_div_r[5:4]); // RULE17 RULE16
      end
      if (cntb_r + 6'h01 >= facb_r) begin
        clkb_nxt = !clkb_r; // RULE19
        cntb_nxt = 6'h00;
        facb_nxt = div_factor(eff_mode, {1'b0, pll_div_r[`CR_MASTER_CLOCK_DIVIDER_SEL_BIT]} + 2'b01); // RULE16
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      clka_r <= 1'b0;
      cnta_r <= 6'h00;
      faca_r <= 6'h02;
      clkb_r <= 1'b0;
      cntb_r <= 6'h00;
      facb_r <= 6'h02;
    end else begin
      clka_r <= clka_nxt;
      cnta_r <= cnta_nxt;
      faca_r <= faca_nxt;
      clkb_r <= clkb_nxt;
      cntb_r <= cntb_nxt;
      facb_r <= facb_nxt;
    end
  end

  // ==========================================================
  // Output selectors
  clk_switch aux_sw (
    .clock(CLOCK),
    .reset(RESET),
    .src0(clka_r),
    .src1(osc_lvl_r),
    .sel(clk_src_r[`CR_AUXSRC_BIT]), // RULE1
    .sel_rst(1'b1),
    .out_r(AUX_CLK_O)
  );

  // Master clock pin reaches the transmitter through its two-flop synchroniser and tx_sw, with no ratio check
  clk_switch tx_sw (
    .clock(CLOCK),
    .reset(RESET),
    .src0(clkb_r),
    .src1(mclk_s2_r),
    .sel(tx_cfg_r[`CR_TX_DATA_SOURCE_SEL_BIT]), // RULE4 RULE5
    .sel_rst(1'b1),
    .out_r(TX_REF_CLK)
  );

  assign AUX_CLK_OE = clk_src_r[`CR_PINEN_BIT]; // RULE3
  assign TX_DATA_SEL = tx_cfg_r[`CR_TX_DATA_SOURCE_SEL_BIT]; // RULE4
  assign MCLK_SRC_SEL = clk_src_r[`CR_MCLKSRC_BIT];

  // ==========================================================
  // Checks
  pin_enable_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE3
    REG_REQ.wr && REG_REQ.addr == `CR_ADDR_CLK_SRC |=> AUX_CLK_OE == $past(REG_REQ.wdata[4]))
    else $error("aux pin enable does not follow write");

  tx_source_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE4
    REG_REQ.wr && REG_REQ.addr == `CR_ADDR_TX_CFG |=> TX_DATA_SEL == $past(REG_REQ.wdata[6]))
    else $error("tx data source does not follow write");

  pll_reset_a: assert property (@(posedge CLOCK) // RULE12
    RESET ##1 !RESET |-> PLL_CFG.n == 4'h7 && PLL_CFG.k == 22'h36fd21 && !PLL_CFG.prescale)
    else $error("pll settings wrong after reset");

  prescale_half_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE13
    OSC_EDGE && prescale_r && ref_seen_r |-> !PLL_REF_EDGE)
    else $error("prescaled reference not halved");

  div_glitch_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE19
    $changed(clka_r) || $changed(clkb_r) |-> $past(PLL_EDGE))
    else $error("divided clock moved without pll edge");

  trim_step_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE6
    rx_state_r == clkroute_pkg::RX_TRACK && $past(rx_state_r) == clkroute_pkg::RX_TRACK && $changed(trim_r)
    |-> $past(frame_edge))
    else $error("trim changed outside a frame edge");

  rate_class_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE7
    rx_state_r == clkroute_pkg::RX_TRACK && frame_edge && per_cnt_r >= M3_LO[13:0] && per_cnt_r <= M3_HI[13:0]
    |=> rate_code_r == clkroute_pkg::RATE_MODE3 && locked_r)
    else $error("mode 3 period not classified");

  auto_mode_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE11
    rx_active ##1 rx_active |-> PLL_DIV_MODE == rate_code_r)
    else $error("divide mode not driven by receiver");

  status_read_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE20
    REG_REQ.rd && REG_REQ.addr == `CR_ADDR_STATUS |=> RDATA[1:0] == $past(rate_code_r))
    else $error("status read lost rate code");

endmodule : clock_routing

// *** verif/clk_partner.sv ***
/*
  Far side of the clock routing block: oscillator and PLL edge pulses,
  a master clock pin and a received frame pin.
  Assumes the system clock of the block; a frame period of 0 stops frames.
*/
module clk_partner (
  input wire logic clock,
  input wire logic reset,
  input wire logic [15:0] frame_period,
  output logic osc_edge,
  output logic pll_edge,
  output logic mclk,
  output logic rx_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] free_r;
  logic [15:0] cnt_r;

  initial begin
    free_r = 8'h0;
    cnt_r = 16'h0;
    {osc_edge, pll_edge, mclk, rx_frame} = 4'h0;
  end

  // ==========================================================
  // Free-running edges, master clock, frame pin
  always @(posedge clock) begin
    free_r <= free_r + 8'h1;
    cnt_r <= (reset || cnt_r + 16'h1 >= frame_period) ? 16'h0 : cnt_r + 16'h1;
    osc_edge <= (free_r[1:0] == 2'h0);
    pll_edge <= free_r[0];
    mclk <= free_r[3];
    rx_frame <= (frame_period != 16'h0) && (cnt_r < 16'h4);
  end
endmodule : clk_partner

// *** verif/tb.sv ***
/*
  Self-checking bench: register port, aux and transmitter clock selection,
  prescale and receive rate classification.
  Assumes clk_partner on the far side and the default period bounds.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  clkroute_pkg::reg_req_s req = '0;
  clkroute_pkg::pll_cfg_s pll_cfg;
  logic [7:0] rdata;
  logic [15:0] frame_period = 16'h0;
  logic osc_edge, pll_edge, mclk, rx_frame;
  logic [1:0] div_mode;
  logic ref_edge, pll_pd, rx_pd, aux_o, aux_oe, tx_sel, tx_ref, mclk_sel;
  logic aux_q = 1'b0;
  logic tx_q = 1'b0;
  int mismatches = 0;
  int check_count = 0;
  int aux_n = 0;
  int tx_n = 0;
  int ref_n = 0;

  always #2.5 clock = ~clock;

  clk_partner far (.clock(clock), .reset(reset), .frame_period(frame_period), .osc_edge(osc_edge),
    .pll_edge(pll_edge), .mclk(mclk), .rx_frame(rx_frame));

  clock_routing DUT (.CLOCK(clock), .RESET(reset), .REG_REQ(req), .RDATA(rdata),
    .OSC_EDGE(osc_edge), .PLL_EDGE(pll_edge), .RX_FRAME(rx_frame), .MCLK_IN(mclk),
    .PLL_CFG(pll_cfg), .PLL_DIV_MODE(div_mode), .PLL_REF_EDGE(ref_edge), .PLL_PD(pll_pd),
    .RX_PD(rx_pd), .AUX_CLK_O(aux_o), .AUX_CLK_OE(aux_oe), .TX_DATA_SEL(tx_sel),
    .TX_REF_CLK(tx_ref), .MCLK_SRC_SEL(mclk_sel));

  // ==========================================================
  // Edge counters on the clock outputs
  always @(posedge clock) begin
    aux_q <= aux_o;
    tx_q <= tx_ref;
    if (aux_o && !aux_q) aux_n <= aux_n + 1;
    if (tx_ref && !tx_q) tx_n <= tx_n + 1;
    if (ref_edge) ref_n <= ref_n + 1;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic near(input string name, input int n, input int e);
    chk(name, 32'(n >= e - 1 && n <= e + 1), 32'h1);
  endtask : near

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h0};
    @(posedge clock);
    req <= '0;
    #1 d = rdata;
  endtask : rd

  // Prescale and integer byte, then the three fraction bytes
  task automatic load_pll(input logic [7:0] n, input logic [23:0] k);
    wr(8'h20, n);
    wr(8'h21, k[7:0]);
    wr(8'h22, k[15:8]);
    wr(8'h23, k[23:16]);
  endtask : load_pll

  // Rises of aux and tx clocks and reference pulses over 160 cycles
  task automatic span(output int a, output int t, output int p);
    int a0, t0, p0;
    repeat (40) @(posedge clock);
    a0 = aux_n;
    t0 = tx_n;
    p0 = ref_n;
    repeat (160) @(posedge clock);
    a = aux_n - a0;
    t = tx_n - t0;
    p = ref_n - p0;
  endtask : span

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] d;
    logic [7:0] a [10] = '{8'h07, 8'h08, 8'h15, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h30};
    logic [7:0] e [10] = '{8'h14, 8'h18, 8'h40, 8'h07, 8'h21, 8'hfd, 8'h36, 8'h03, 8'h02, 8'h00};
    for (int i = 0; i < 10; i++) begin
      rd(a[i], d);
      chk("reset value", d, e[i]);
    end
    chk("pll cfg", pll_cfg, {1'b0, 1'b1, 4'h7, 22'h36fd21});
    chk("aux oe", aux_oe, 1'b1);
    chk("tx sel", tx_sel, 1'b1);
    chk("mclk sel", mclk_sel, 1'b0);
  endtask : t_reset

  task automatic t_aux;
    int a, t, p;
    wr(8'h07, 8'h34);
    span(a, t, p);
    near("aux osc", a, 20);
    wr(8'h08, 8'h10);
    span(a, t, p);
    near("aux div 11", a, 5);
    wr(8'h07, 8'h14);
    span(a, t, p);
    near("aux div 01", a, 20);
    wr(8'h08, 8'h08);
    #1 chk("aux oe", aux_oe, 1'b0);
    wr(8'h08, 8'h18);
  endtask : t_aux

  task automatic t_tx;
    int a, t, p;
    wr(8'h15, 8'h00);
    span(a, t, p);
    chk("tx sel", tx_sel, 1'b0);
    near("tx clock b", t, 20);
    wr(8'h15, 8'h40);
    span(a, t, p);
    near("tx mclk", t, 10);
  endtask : t_tx

  task automatic t_prescale;
    int a, t, p;
    span(a, t, p);
    near("ref direct", p, 40);
    wr(8'h20, 8'h17);
    span(a, t, p);
    near("ref halved", p, 20);
    wr(8'h20, 8'h07);
  endtask : t_prescale

  task automatic t_rx;
    logic [7:0] d;
    logic [15:0] per [5] = '{16'd2200, 16'd4400, 16'd6250, 16'd1100, 16'd2200};
    logic [1:0] code [5] = '{2'b01, 2'b10, 2'b11, 2'b00, 2'b01};
    load_pll(8'h07, 24'h36fd21);
    wr(8'h24, 8'h02);
    #1 chk("power", {pll_pd, rx_pd}, 2'b01);
    wr(8'h24, 8'h00);
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      frame_period <= per[i];
      repeat (3 * per[i]) @(posedge clock);
      rd(8'h25, d);
      chk("rate and mode", d[3:0], {code[i], code[i]});
      chk("div mode", div_mode, code[i]);
      chk("frac en", pll_cfg.frac_en, 1'b1);
      if (i >= 3) begin
        load_pll(i == 3 ? 8'h08 : 8'h07, i == 3 ? 24'h0c49ba : 24'h36fd21);
        #1 chk("n ratio", pll_cfg.n, i == 3 ? 4'h8 : 4'h7);
      end
    end
    wr(8'h25, 8'hff);
    rd(8'h25, d);
    chk("status read only", d[1:0], 2'b01);
  endtask : t_rx

  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic final_report;
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    t_reset;
    t_aux;
    t_tx;
    t_prescale;
    t_rx;
    final_report;
  end

  initial begin
    repeat (65000) @(posedge clock);
    mismatches++;
    final_report;
  end
endmodule : tb
